// ===== hdl/usu_pkg.sv
/*
  Constants, field layout and state type of the universal serial unit.
  Assumes an APB register bus with 32-bit data and word-aligned registers.
*/
// Functional notes
// - Data register reads and writes hit shifter directly
// - Data write beats a same-cycle shift clock
// - Shift toward MSB on the selected clock
// - Pin inputs usable even with outputs disabled
// - Serial output comes from bit 7 via latch
// - Latch half-open external, always open internal
// - Open latch passes new MSB at once
// - Data output driven only when direction bit set
// - Two-wire start condition sets start flag
// - Start flag write-one clear releases clock hold
// - Non two-wire external clock edge sets start
// - Start interrupt when flag and both enables
// - Counter wrap 15 to 0 sets overflow
// - Overflow write-one clear releases clock hold
// - Overflow interrupt when flag and both enables
// - Two-wire stop sets stop flag, no interrupt
// - Collision bit is bit 7 versus pin
// - Counter readable and writable in status
// - Counter counts every selected clock
// - External source with strobe bit uses toggle
// - Pending flag interrupts once enables set
// - Wire mode affects outputs, start/stop detection and clock hold
// - Wire mode codes off, three-wire, two-wire
// - Mode 11 holds clock low on overflow
// - Source 10 shifts rising, counts both edges
package usu_pkg;

  // ==========================================================
  // Register indices, byte address is four times the index
  // ==========================================================
  localparam logic [7:0] IDX_CTRL   = 8'hb8;
  localparam logic [7:0] IDX_STATUS = 8'hb9;
  localparam logic [7:0] IDX_DATA   = 8'hba;
  localparam logic [7:0] IDX_PORT   = 8'hbb;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_SIE    = 7;
  localparam int CTRL_OIE    = 6;
  localparam int CTRL_WM_LO  = 4;
  localparam int CTRL_CS_LO  = 2;
  localparam int CTRL_CLK    = 1;
  localparam int CTRL_TC     = 0;
  localparam int STAT_START  = 7;
  localparam int STAT_OVF    = 6;
  localparam int STAT_STOP   = 5;
  localparam int PORT_DDIR   = 0;
  localparam int PORT_CDIR   = 1;
  localparam int PORT_DPORT  = 2;
  localparam int PORT_CPORT  = 3;
  localparam int PORT_GIE    = 4;

  // ==========================================================
  // Encodings and reset values
  // ==========================================================
  localparam logic [1:0] WM_OFF   = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO_H = 2'h3;
  localparam logic [1:0] CS_SOFT  = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [3:0] CNT_MAX  = 4'hf;

  typedef struct packed {
    logic [7:0] sr;
    logic       latch;
    logic [3:0] cnt;
    logic       start_f;
    logic       ovf_f;
    logic       stop_f;
    logic       start_hold;
    logic       sie;
    logic       oie;
    logic [1:0] wm;
    logic [1:0] cs;
    logic       clk_sel;
    logic       data_dir;
    logic       clk_dir;
    logic       data_port;
    logic       clk_port;
    logic       gie;
    logic       sda_prev;
    logic       scl_prev;
  } usu_state_s;

endpackage

// ===== hdl/usu_sync.sv
/*
  Two-flop synchroniser for pin levels entering the pclk domain.
  Assumes inputs may change at any time relative to pclk.
*/
`timescale 1ns/10ps
module usu_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } usu_sync_s;

  usu_sync_s st;
  usu_sync_s next_st;

  // ==========================================================
  // First stage feeds only the second
  // ==========================================================
  always_comb begin
    next_st        = st;
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule

// ===== hdl/usu_core.sv
/*
  Universal serial unit: 8-bit shifter, 4-bit clock counter, start and
  stop detection, two-wire clock hold, APB register slave.
  Assumes pin inputs are asynchronous and timer_match is a pclk pulse.
*/
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module usu_core
  import usu_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          timer_match,
  input  wire logic          serial_in_pin,
  output logic               data_o,
  output logic               data_oe,
  input  wire logic          serial_clock_pin,
  output logic               sclk_o,
  output logic               sclk_oe,
  output logic               start_irq,
  output logic               overflow_irq,
  output logic               wake_any_sleep,
  output logic               wake_idle_sleep
);

  usu_state_s st;
  usu_state_s next_st;

  logic [1:0]    pins_s;
  logic          sda_s;
  logic          scl_s;
  logic [AW-3:0] word_idx;
  logic          acc;
  logic          wr;
  logic          sel_ctrl;
  logic          sel_stat;
  logic          sel_data;
  logic          sel_port;
  logic          mapped;
  logic          ctrl_wr;
  logic          stat_wr;
  logic          data_wr;
  logic          port_wr;
  logic          scl_rise;
  logic          scl_fall;
  logic          sda_rise;
  logic          sda_fall;
  logic          ext_src;
  logic          sw_strobe;
  logic          tc_strobe;
  logic          timer_tick;
  logic          ext_shift;
  logic          ext_count;
  logic          shift_tick;
  logic          cnt_tick;
  logic          latch_open;
  logic          start_set;
  logic          stop_set;
  logic          two_wire;
  logic          scl_hold;
  logic          collision;

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  // Inputs are always sampled whatever the wire mode
  usu_sync #(
    .W (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({serial_clock_pin, serial_in_pin}),
    .sync_out (pins_s)
  );

  assign sda_s    = pins_s[0];
  assign scl_s    = pins_s[1];
  assign scl_rise = scl_s & ~st.scl_prev;
  assign scl_fall = ~scl_s & st.scl_prev;
  assign sda_rise = sda_s & ~st.sda_prev;
  assign sda_fall = ~sda_s & st.sda_prev;

  // ==========================================================
  // APB decode
  // ==========================================================
  // Zero wait states; unmapped words answer with an error
  assign word_idx = paddr[AW-1:2];
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign sel_ctrl = word_idx == (AW-2)'(IDX_CTRL);
  assign sel_stat = word_idx == (AW-2)'(IDX_STATUS);
  assign sel_data = word_idx == (AW-2)'(IDX_DATA);
  assign sel_port = word_idx == (AW-2)'(IDX_PORT);
  assign mapped   = sel_ctrl | sel_stat | sel_data | sel_port;
  assign ctrl_wr  = wr & sel_ctrl;
  assign stat_wr  = wr & sel_stat;
  assign data_wr  = wr & sel_data;
  assign port_wr  = wr & sel_port;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;

  assign collision = st.sr[7] ^ sda_s;

  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_ctrl) begin
      prdata[7:0] = {st.sie, st.oie, st.wm, st.cs, 2'h0};
    end else if (sel_stat) begin
      prdata[7:0] = {st.start_f, st.ovf_f, st.stop_f, collision, st.cnt};
    end else if (sel_data) begin
      prdata[7:0] = st.sr;
    end else if (sel_port) begin
      prdata[7:0] = {3'h0, st.gie, st.clk_port, st.data_port, st.clk_dir, st.data_dir};
    end
  end

  // ==========================================================
  // Clock source selection
  // ==========================================================
  assign ext_src    = st.cs[1];
  assign sw_strobe  = ctrl_wr & pwdata[CTRL_CLK] &
                      (pwdata[CTRL_CS_LO+1:CTRL_CS_LO] == CS_SOFT);
  assign tc_strobe  = ctrl_wr & pwdata[CTRL_TC] & pwdata[CTRL_CS_LO+1] &
                      pwdata[CTRL_CLK];
  assign timer_tick = (st.cs == CS_TIMER) & timer_match;
  // Source 10 shifts on rise, 11 on fall; counter sees both edges
  assign ext_shift  = ext_src & ~st.clk_sel &
                      (st.cs[0] ? scl_fall : scl_rise);
  assign ext_count  = ext_src & ~st.clk_sel & (scl_rise | scl_fall);
  assign shift_tick = sw_strobe | tc_strobe | timer_tick | ext_shift;
  assign cnt_tick   = sw_strobe | tc_strobe | timer_tick | ext_count;

  // Latch is open in the half-cycle opposite the sampling edge
  assign latch_open = ~ext_src | (st.cs[0] ? scl_s : ~scl_s);

  // ==========================================================
  // Line condition detection
  // ==========================================================
  assign two_wire  = st.wm[1];
  assign start_set = (two_wire & sda_fall & scl_s) |
                     (~two_wire & ext_src & ~st.clk_sel & (scl_rise | scl_fall));
  assign stop_set  = two_wire & sda_rise & scl_s;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st          = st;
    next_st.sda_prev = sda_s;
    next_st.scl_prev = scl_s;

    // Shifter: a data write in the same cycle wins over the shift
    if (data_wr) begin
      next_st.sr = pwdata[7:0];
    end else if (shift_tick) begin
      next_st.sr = {st.sr[6:0], sda_s};
    end
    next_st.latch = latch_open ? next_st.sr[7] : st.latch;

    // Counter: software write beats a clock in the same cycle
    if (stat_wr) begin
      next_st.cnt = pwdata[3:0];
    end else if (cnt_tick) begin
      next_st.cnt = st.cnt + 4'h1;
    end

    // Flags: start and stop hardware set wins over write-one clear; a status write blocks the overflow set
    next_st.start_f = start_set |
                      (st.start_f & ~(stat_wr & pwdata[STAT_START]));
    next_st.ovf_f   = (cnt_tick & ~stat_wr & (st.cnt == CNT_MAX)) |
                      (st.ovf_f & ~(stat_wr & pwdata[STAT_OVF]));
    next_st.stop_f  = stop_set |
                      (st.stop_f & ~(stat_wr & pwdata[STAT_STOP]));

    // Start hold grabs the clock at the master's first falling edge
    if (!next_st.start_f || !two_wire) begin
      next_st.start_hold = 1'b0;
    end else if (st.start_f && scl_fall) begin
      next_st.start_hold = 1'b1;
    end

    if (ctrl_wr) begin
      next_st.sie     = pwdata[CTRL_SIE];
      next_st.oie     = pwdata[CTRL_OIE];
      next_st.wm      = pwdata[CTRL_WM_LO+1:CTRL_WM_LO];
      next_st.cs      = pwdata[CTRL_CS_LO+1:CTRL_CS_LO];
      next_st.clk_sel = pwdata[CTRL_CLK];
    end

    if (port_wr) begin
      next_st.data_dir  = pwdata[PORT_DDIR];
      next_st.clk_dir   = pwdata[PORT_CDIR];
      next_st.data_port = pwdata[PORT_DPORT];
      next_st.clk_port  = pwdata[PORT_CPORT];
      next_st.gie       = pwdata[PORT_GIE];
    end else if (ctrl_wr && pwdata[CTRL_TC]) begin
      // Toggle strobe lets a master make its clock from software
      next_st.clk_port = ~st.clk_port;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Pin drive
  // ==========================================================
  // Two-wire lines are open drain: only ever pulled low
  assign scl_hold = two_wire &
                    (st.start_hold | ((st.wm == WM_TWO_H) & st.ovf_f));
  assign data_oe  = st.data_dir & (~two_wire | ~st.latch | ~st.data_port);
  assign data_o   = ~two_wire & ((st.wm == WM_THREE) ? st.latch : st.data_port);
  assign sclk_oe  = st.clk_dir & (~two_wire | ~st.clk_port | scl_hold);
  assign sclk_o   = ~two_wire & st.clk_port;

  // ==========================================================
  // Interrupt requests
  // ==========================================================
  // Level requests, so a pending flag fires as soon as enabled
  assign start_irq       = st.start_f & st.sie & st.gie;
  assign overflow_irq    = st.ovf_f & st.oie & st.gie;
  assign wake_any_sleep  = start_irq;
  assign wake_idle_sleep = overflow_irq;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence shift_cause;
    shift_tick && !data_wr;
  endsequence

  sequence wrap_cause;
    cnt_tick && !stat_wr && st.cnt == 4'hf;
  endsequence

  shift_toward_msb_a : assert property (
    shift_cause |=> st.sr == {$past(st.sr[6:0]), $past(sda_s)})
    else $error("shifter did not move toward msb");

  write_beats_shift_a : assert property (
    data_wr |=> st.sr == $past(pwdata[7:0]))
    else $error("data write lost to shift");

  counter_wrap_a : assert property (
    wrap_cause |=> st.ovf_f && st.cnt == 4'h0)
    else $error("wrap did not set overflow");

  start_sticky_a : assert property (
    st.start_f && !(stat_wr && pwdata[7]) |=> st.start_f)
    else $error("start flag cleared without write");

  start_irq_rise_a : assert property (
    st.start_f && st.gie && $rose(st.sie) |-> start_irq)
    else $error("pending start not requested");

  stop_detect_a : assert property (
    st.wm[1] && sda_rise && scl_s |=> st.stop_f)
    else $error("stop condition missed");

  data_dir_gate_a : assert property (
    !st.data_dir |-> !data_oe)
    else $error("data pin driven without direction");

  ovf_hold_a : assert property (
    st.wm == 2'h3 && st.ovf_f && st.clk_dir |-> sclk_oe && !sclk_o)
    else $error("clock not held on overflow");

  collision_bit_a : assert property (
    stat_wr == 1'b0 && sel_stat |-> prdata[4] == (st.sr[7] != sda_s))
    else $error("collision bit wrong");

  counter_write_a : assert property (
    stat_wr |=> st.cnt == $past(pwdata[3:0]) ##1 st.cnt == $past(st.cnt) || $past(cnt_tick) || $past(stat_wr))
    else $error("counter write not held");

  overflow_irq_a : assert property (
    overflow_irq |-> st.ovf_f && st.oie && st.gie && wake_idle_sleep)
    else $error("overflow request without cause");

  stop_no_irq_a : assert property (
    $rose(st.stop_f) && !st.start_f && !st.ovf_f |-> !start_irq && !overflow_irq)
    else $error("stop flag raised an interrupt");

  start_hold_flag_a : assert property (
    st.start_hold |-> st.start_f)
    else $error("clock hold without start flag");

  ovf_release_a : assert property (
    st.wm == WM_TWO_H && !st.ovf_f && !st.start_hold |-> !scl_hold)
    else $error("clock held after overflow cleared");

  start_edge_set_a : assert property (
    two_wire && sda_fall && scl_s |=> st.start_f)
    else $error("start condition missed");

  ext_edge_start_a : assert property (
    !two_wire && ext_src && !st.clk_sel && (scl_rise || scl_fall) |=> st.start_f)
    else $error("clock edge did not set start");

  start_irq_cause_a : assert property (
    start_irq |-> st.start_f && st.sie && st.gie && wake_any_sleep)
    else $error("start request without cause");

  stop_sticky_a : assert property (
    st.stop_f && !(stat_wr && pwdata[STAT_STOP]) |=> st.stop_f)
    else $error("stop flag cleared without write");

  count_step_a : assert property (
    cnt_tick && !stat_wr |=> st.cnt == $past(st.cnt) + 4'h1)
    else $error("counter did not step");

  latch_follow_a : assert property (
    !ext_src |=> st.latch == st.sr[7])
    else $error("open latch did not follow msb");

  latch_closed_a : assert property (
    ext_src && !latch_open |=> st.latch == $past(st.latch))
    else $error("closed latch changed");

  three_wire_out_a : assert property (
    st.wm == WM_THREE |-> data_o == st.latch)
    else $error("data output not from latch");

  // Hold grabs the clock once the master pulls it low
  sequence start_grab;
    two_wire && st.start_f && scl_fall && !(stat_wr && pwdata[STAT_START]);
  endsequence

  hold_on_fall_a : assert property (
    start_grab |=> st.start_hold)
    else $error("start hold not taken");

endmodule

// ===== sim/usu_link_model.sv
/*
  Far side of the serial link: a behavioural master that moves the
  data and clock lines. Assumes the bench resolves open-drain levels
  and that one link cycle lasts 160 ns; the clock stands still between frames.
*/
`timescale 1ns/10ps
module usu_link_model (
  output logic sda_drv,
  output logic scl_drv
);
  localparam time HALF = 80;

  // ==========================================================
  // Line control
  // ==========================================================
  initial begin
    sda_drv = 1'b1;
    scl_drv = 1'b0;
  end

  task automatic idle(input logic c, input logic d);
    scl_drv = c;
    sda_drv = d;
    #HALF;
  endtask

  // MSB first, data set while clock low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      #HALF;
      scl_drv = 1'b1;
      #HALF;
      scl_drv = 1'b0;
    end
    // Not kinder than a real line: old value does not linger
    sda_drv = ~b[0];
    #HALF;
  endtask

  task automatic start_cond();
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    #HALF;
    sda_drv = 1'b0;
    #HALF;
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    #HALF;
    scl_drv = 1'b1;
    #HALF;
    sda_drv = 1'b1;
    #HALF;
  endtask
endmodule

// ===== sim/testbench.sv
/*
  Self-checking bench for the universal serial unit over APB.
  Assumes the link partner model and zero-wait APB answers.
*/
`timescale 1ns/10ps
module testbench;
  import usu_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, timer_match, tw, tm_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic        pready, pslverr, data_o, data_oe, sclk_o, sclk_oe, e;
  logic        start_irq, overflow_irq, wake_any_sleep, wake_idle_sleep;
  logic [7:0]  v, b;
  wire         sda_drv, scl_drv, sda_line, scl_line;
  int          err_count, n_compared;

  // Open-drain resolution only in two-wire mode for data
  assign sda_line = sda_drv & ~(tw & data_oe & ~data_o);
  assign scl_line = scl_drv & ~(sclk_oe & ~sclk_o);

  usu_link_model link (.sda_drv(sda_drv), .scl_drv(scl_drv));

  usu_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_match(timer_match), .serial_in_pin(sda_line),
    .data_o(data_o), .data_oe(data_oe), .serial_clock_pin(scl_line), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .start_irq(start_irq), .overflow_irq(overflow_irq),
    .wake_any_sleep(wake_any_sleep), .wake_idle_sleep(wake_idle_sleep));

  // ==========================================================
  // Helpers
  // ==========================================================
  always #5 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] shl(input logic [7:0] s, input logic in);
    return {s[6:0], in};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable     <= 1'b1;
    timer_match <= tm_pulse;
    // No wait count assumed; the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel        <= 1'b0;
    penable     <= 1'b0;
    timer_match <= 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    logic        y;
    apb(idx, 1'b1, d, x, y);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [31:0] x);
    logic y;
    apb(idx, 1'b0, 8'h00, x, y);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // ==========================================================
  // Watchdog, generous against a run of about five hundred cycles
  // ==========================================================
  initial begin
    #200000;
    err_count++;
    summarize();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    {pclk, presetn, psel, penable, pwrite, timer_match, tw, tm_pulse} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'h326ddcb9;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reg_rd(8'(IDX_CTRL + i), r);
      // Idle data pin is high, so the collision bit reads one
      chk(r, {24'h0, RST_REG} | ((i == 1) ? 32'h10 : 32'h0));
    end
    apb(8'hc0, 1'b1, 8'hff, r, e);
    apb(8'hc0, 1'b0, 8'h00, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    repeat (4) begin
      seed = lfsr(seed);
      reg_wr(IDX_DATA, seed[7:0]);
      reg_rd(IDX_DATA, r);
      chk(r, {24'h0, seed[7:0]});
    end
    // Software strobe across the counter wrap
    v = seed[15:8];
    reg_wr(IDX_DATA, v);
    reg_wr(IDX_STATUS, 8'hee);
    repeat (2) reg_wr(IDX_CTRL, 8'h02);
    reg_rd(IDX_DATA, r);
    chk(r, {24'h0, shl(shl(v, 1'b1), 1'b1)});
    reg_rd(IDX_STATUS, r);
    chk(r & 32'hef, 32'h40);
    chk({31'h0, overflow_irq}, 32'h0);
    reg_wr(IDX_PORT, 8'h10);
    reg_wr(IDX_CTRL, 8'h40);
    settle();
    chk({31'h0, overflow_irq}, 32'h1);
    chk({31'h0, wake_idle_sleep}, 32'h1);
    reg_wr(IDX_STATUS, 8'h40);
    settle();
    chk({31'h0, overflow_irq}, 32'h0);
    // Timer source, write wins over same-cycle shift
    reg_wr(IDX_CTRL, 8'h04);
    tm_pulse = 1'b1;
    reg_wr(IDX_DATA, v);
    tm_pulse = 1'b0;
    reg_rd(IDX_DATA, r);
    chk(r, {24'h0, v});
    reg_wr(IDX_STATUS, 8'h05);
    @(posedge pclk) timer_match <= 1'b1;
    @(posedge pclk) timer_match <= 1'b0;
    reg_rd(IDX_DATA, r);
    chk(r, {24'h0, shl(v, 1'b1)});
    reg_rd(IDX_STATUS, r);
    chk(r & 32'h0f, 32'h6);
    // External clock in three-wire mode
    reg_wr(IDX_PORT, 8'h11);
    reg_wr(IDX_CTRL, 8'h18);
    reg_wr(IDX_STATUS, 8'he0);
    seed = lfsr(seed);
    b = seed[7:0];
    link.send_byte(b);
    reg_rd(IDX_DATA, r);
    chk(r, {24'h0, b});
    reg_rd(IDX_STATUS, r);
    chk(r & 32'hef, 32'hc0);
    reg_wr(IDX_STATUS, 8'he0);
    reg_wr(IDX_CTRL, 8'h1b);
    reg_rd(IDX_DATA, r);
    chk(r, {24'h0, shl(b, ~b[0])});
    reg_rd(IDX_STATUS, r);
    chk(r & 32'h0f, 32'h1);
    reg_wr(IDX_CTRL, 8'h18);
    reg_wr(IDX_DATA, 8'h80);
    settle();
    chk({31'h0, data_o}, 32'h1);
    chk({31'h0, data_oe}, 32'h1);
    reg_wr(IDX_DATA, 8'h00);
    settle();
    chk({31'h0, data_o}, 32'h0);
    reg_wr(IDX_PORT, 8'h10);
    settle();
    chk({31'h0, data_oe}, 32'h0);
    // Source 11: shift on fall only, count both edges
    reg_wr(IDX_CTRL, 8'h1c);
    reg_wr(IDX_STATUS, 8'he0);
    link.idle(1'b1, 1'b1);
    reg_rd(IDX_DATA, r);
    chk(r, 32'h0);
    link.idle(1'b0, 1'b1);
    reg_rd(IDX_DATA, r);
    chk(r, 32'h1);
    reg_rd(IDX_STATUS, r);
    chk(r & 32'hef, 32'h82);
    // Two-wire start, stop and collision
    tw = 1'b1;
    link.idle(1'b1, 1'b1);
    reg_wr(IDX_CTRL, 8'ha0);
    reg_wr(IDX_STATUS, 8'he0);
    link.start_cond();
    reg_rd(IDX_STATUS, r);
    chk(r & 32'h80, 32'h80);
    chk({31'h0, start_irq}, 32'h1);
    chk({31'h0, wake_any_sleep}, 32'h1);
    reg_wr(IDX_STATUS, 8'h80);
    settle();
    chk({31'h0, start_irq}, 32'h0);
    link.stop_cond();
    reg_rd(IDX_STATUS, r);
    chk(r & 32'ha0, 32'h20);
    chk({31'h0, start_irq}, 32'h0);
    reg_wr(IDX_PORT, 8'h11);
    reg_wr(IDX_DATA, 8'h80);
    link.idle(1'b1, 1'b0);
    reg_rd(IDX_STATUS, r);
    chk(r & 32'h10, 32'h10);
    link.idle(1'b1, 1'b1);
    reg_wr(IDX_DATA, 8'h00);
    settle();
    reg_rd(IDX_STATUS, r);
    chk(r & 32'h10, 32'h0);
    // Mode 11 overflow hold, then start hold on the master's fall
    reg_wr(IDX_PORT, 8'h1e);
    reg_wr(IDX_CTRL, 8'h30);
    reg_wr(IDX_STATUS, 8'hef);
    reg_wr(IDX_CTRL, 8'h32);
    settle();
    chk({31'h0, sclk_oe}, 32'h1);
    chk({31'h0, sclk_o}, 32'h0);
    reg_wr(IDX_STATUS, 8'h40);
    settle();
    chk({31'h0, sclk_oe}, 32'h0);
    link.start_cond();
    link.idle(1'b0, 1'b0);
    chk({31'h0, sclk_oe}, 32'h1);
    reg_wr(IDX_STATUS, 8'h80);
    settle();
    chk({31'h0, sclk_oe}, 32'h0);
    summarize();
  end
endmodule
